/* design/csc_defs.svh */
// csc_defs.svh: offsets, keys and counts of the stack/regfile/guard block
// assumes: included by both ends and the checker; definitions only
//
// Functional notes
// RL1: push minus one, pop plus one
// RL2: reset loads stack pointer with SRAM top
// RL3: call pushes two bytes, low byte higher
// RL4: pushed return address is a word address
// RL5: returns pop two bytes, pointer plus two
// RL6: low pointer write blocks interrupts four instructions
// RL7: relocated stack must sit above 0x2000
// RL8: thirty-two eight-bit single-cycle working registers
// RL9: four read and write port arrangements
// RL10: top six registers form three pointers
// RL11: memory load and indirect jumps use third pointer
// RL12: pointers support displacement, increment, decrement
// RL13: register file has its own address space
// RL14: low write to temp, high write commits
// RL15: low read latches high byte into temp
// RL16: software writes low byte before high
// RL17: software reads low byte before high
// RL18: temp byte directly readable and writable
// RL19: guard key gates two distinct unlock modes
// RL20: protected write within four instructions after key
// RL21: memory writes, flash access, sleep close window
// RL22: two keys open four-instruction windows
// RL23: guard bits show open mode, rest zero
// RL24: open window holds off all interrupts
`ifndef CSC_DEFS_SVH
`define CSC_DEFS_SVH
`define CSC_IO_GUARD      6'h04
`define CSC_IO_TEMP       6'h08
`define CSC_IO_SP_LO      6'h0d
`define CSC_IO_SP_HI      6'h0e
`define CSC_KEY_SPM       8'h9d
`define CSC_KEY_IO        8'hd8
`define CSC_WIN_INSNS     3'h4
`define CSC_GUARD_RESET   8'h00
`define CSC_STACK_FLOOR   16'h2000
`define CSC_RF_PTR_BASE   5'h1a
`define CSC_HR_CMD        2'h0
`define CSC_HR_DATA       2'h1
`define CSC_HR_RESULT     2'h2
`define CSC_HR_STATUS     2'h3
`define CSC_CMD_OP_LSB    0
`define CSC_CMD_ADR_LSB   8
`define CSC_CMD_SEL_LSB   16
`define CSC_CMD_AM_LSB    18
`define CSC_CMD_ZONLY_BIT 20
`define CSC_CMD_DISP_LSB  24
`endif

/* design/csc_pkg.sv */
// csc_pkg: types shared by both ends of the stack/regfile/guard link
// assumes: csc_defs.svh on the include path
package csc_pkg;
  typedef enum logic [2:0] {
    CSC_STK_NONE = 3'h0, CSC_STK_PUSH = 3'h1, CSC_STK_POP = 3'h3,
    CSC_STK_CALL = 3'h2, CSC_STK_RET  = 3'h6
  } csc_stk_op_t;
  typedef enum logic [1:0] {CSC_PTR_X = 2'h0, CSC_PTR_Y = 2'h1, CSC_PTR_Z = 2'h2} csc_ptr_t;
  typedef enum logic [1:0] {CSC_AM_DISP = 2'h0, CSC_AM_INC = 2'h1, CSC_AM_DEC = 2'h2} csc_am_t;
  typedef enum logic [1:0] {CSC_G_IDLE = 2'b00, CSC_G_IO = 2'b01, CSC_G_SPM = 2'b11} csc_guard_t;
  typedef enum logic {CSC_SQ_IDLE = 1'b0, CSC_SQ_SECOND = 1'b1} csc_sq_t;
  typedef enum logic [1:0] {CSC_H_IDLE = 2'b00, CSC_H_ISSUE = 2'b01, CSC_H_WAIT = 2'b11} csc_hst_t;
  typedef enum logic [3:0] {
    CSC_C_NOP = 4'h0, CSC_C_IO_WR = 4'h1, CSC_C_IO_RD = 4'h2, CSC_C_RF_WR8 = 4'h3,
    CSC_C_RF_WR16 = 4'h4, CSC_C_RF_RD = 4'h5, CSC_C_PUSH = 4'h6, CSC_C_POP = 4'h7,
    CSC_C_CALL = 4'h8, CSC_C_RET = 4'h9, CSC_C_PTR = 4'ha, CSC_C_DATA_WR = 4'hb,
    CSC_C_NVM = 4'hc, CSC_C_SLEEP = 4'hd
  } csc_cmd_t;
endpackage

/* design/csc_link_if.sv */
// csc_link_if: sequencer-to-core link for stack, registers and guard
// assumes: one clock, both ends on clk_sys
`timescale 1ns/1ps
`default_nettype none
interface csc_link_if;
  import csc_pkg::*;
  // instruction events
  logic        instr_retire;
  logic        data_we;
  logic        nvm_access;
  logic        sleep_exec;
  // i/o space
  logic [5:0]  io_addr;
  logic [7:0]  io_wdata;
  logic        io_we;
  logic        io_re;
  logic [7:0]  io_rdata;
  // register file
  logic [4:0]  rf_ra_a;
  logic [4:0]  rf_ra_b;
  logic [7:0]  rf_rd_a;
  logic [7:0]  rf_rd_b;
  logic [15:0] rf_rd_w;
  logic [4:0]  rf_wa;
  logic [15:0] rf_wd;
  logic        rf_we8;
  logic        rf_we16;
  // pointer addressing
  logic        ptr_go;
  csc_ptr_t    ptr_sel;
  csc_am_t     ptr_mode;
  logic [5:0]  ptr_disp;
  logic        ptr_zonly;
  logic [15:0] ptr_ea;
  // stack
  csc_stk_op_t stk_op;
  logic [7:0]  stk_push_data;
  logic [16:0] stk_pc_byte;
  logic        stk_busy;
  logic [7:0]  stk_pop_data;
  logic [15:0] stk_ret_pc;
  logic        stk_we;
  logic [15:0] stk_addr;
  logic [7:0]  stk_wdata;
  logic [7:0]  stk_rdata;
  // status
  logic        irq_block;
  logic        guard_io_open;
  logic        guard_spm_open;
  modport core (
    input  instr_retire, data_we, nvm_access, sleep_exec,
    input  io_addr, io_wdata, io_we, io_re, output io_rdata,
    input  rf_ra_a, rf_ra_b, rf_wa, rf_wd, rf_we8, rf_we16,
    output rf_rd_a, rf_rd_b, rf_rd_w,
    input  ptr_go, ptr_sel, ptr_mode, ptr_disp, ptr_zonly, output ptr_ea,
    input  stk_op, stk_push_data, stk_pc_byte, stk_rdata,
    output stk_busy, stk_pop_data, stk_ret_pc, stk_we, stk_addr, stk_wdata,
    output irq_block, guard_io_open, guard_spm_open
  );
  modport seq (
    output instr_retire, data_we, nvm_access, sleep_exec,
    output io_addr, io_wdata, io_we, io_re, input io_rdata,
    output rf_ra_a, rf_ra_b, rf_wa, rf_wd, rf_we8, rf_we16,
    input  rf_rd_a, rf_rd_b, rf_rd_w,
    output ptr_go, ptr_sel, ptr_mode, ptr_disp, ptr_zonly, input ptr_ea,
    output stk_op, stk_push_data, stk_pc_byte, stk_rdata,
    input  stk_busy, stk_pop_data, stk_ret_pc, stk_we, stk_addr, stk_wdata,
    input  irq_block, guard_io_open, guard_spm_open
  );
endinterface
`default_nettype wire

/* design/csc_core.sv */
// csc_core: stack pointer, working registers, temp byte and change guard
// assumes: sequencer on csc_link_if.seq owns the data memory for the stack
`include "csc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module csc_core
  import csc_pkg::*;
#(
  parameter int          SP_W     = 16,
  parameter logic [15:0] SRAM_TOP = 16'h3fff
)(
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic nrst,
  // link to the sequencer
  csc_link_if.core  lnk
);
  initial
  begin
    if (SP_W < 8 || SP_W > 16)
      $error("csc_core: SP_W must be 8..16");
  end

  localparam logic [15:0] SP_MASK = 16'hffff >> (16 - SP_W);

  ////////////////////////////////////////////////////////////////////////////
  // register file

  logic [7:0]  rf_q [32];
  logic [4:0]  pair_lo;
  logic [15:0] pair_val;
  logic [15:0] ptr_ea_q;
  csc_ptr_t    sel_eff;

  function automatic logic [4:0] pair_base(input csc_ptr_t p);
    pair_base = `CSC_RF_PTR_BASE + {2'h0, p, 1'b0}; // RL10
  endfunction

  function automatic logic [15:0] rf_pair(input logic [4:0] lo);
    rf_pair = {rf_q[{lo[4:1], 1'b1}], rf_q[{lo[4:1], 1'b0}]}; // RL10
  endfunction

  // reads are plain muxes, so every register is reachable in one cycle
  assign lnk.rf_rd_a = rf_q[lnk.rf_ra_a]; // RL8 RL9
  assign lnk.rf_rd_b = rf_q[lnk.rf_ra_b]; // RL9

  assign sel_eff  = lnk.ptr_zonly ? CSC_PTR_Z : lnk.ptr_sel; // RL11
  assign pair_lo  = pair_base(sel_eff);
  always_comb
  begin
    pair_val    = rf_pair(pair_lo);
    lnk.rf_rd_w = rf_pair(lnk.rf_ra_a); // RL9
  end

  // explicit result writes win over pointer write-back in the same cycle
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < 32; i++)
        rf_q[i] <= 8'h00;
    end
    else
    begin
      if (lnk.ptr_go && lnk.ptr_mode != CSC_AM_DISP)
      begin
        if (lnk.ptr_mode == CSC_AM_INC)
          {rf_q[pair_lo + 5'h01], rf_q[pair_lo]} <= pair_val + 16'h0001; // RL12
        else
          {rf_q[pair_lo + 5'h01], rf_q[pair_lo]} <= pair_val - 16'h0001; // RL12
      end
      if (lnk.rf_we16)
        {rf_q[{lnk.rf_wa[4:1], 1'b1}], rf_q[{lnk.rf_wa[4:1], 1'b0}]} <= lnk.rf_wd; // RL9
      else if (lnk.rf_we8)
        rf_q[lnk.rf_wa] <= lnk.rf_wd[7:0]; // RL8 RL9
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      ptr_ea_q <= 16'h0000;
    else if (lnk.ptr_go)
    begin
      case (lnk.ptr_mode)
        CSC_AM_DISP: ptr_ea_q <= pair_val + {10'h000, lnk.ptr_disp}; // RL12
        CSC_AM_INC:  ptr_ea_q <= pair_val; // RL12
        CSC_AM_DEC:  ptr_ea_q <= pair_val - 16'h0001; // RL12
        default:     ptr_ea_q <= pair_val;
      endcase
    end
  end
  assign lnk.ptr_ea = ptr_ea_q;

  ////////////////////////////////////////////////////////////////////////////
  // i/o space: stack pointer, temp byte, guard
  // the working registers are not decoded here at all // RL13

  logic [15:0] sp_q;
  logic [7:0]  temp_q;
  logic [7:0]  io_rdata_q;
  logic [7:0]  io_rd_mux;
  logic [2:0]  hold_q;
  logic [2:0]  win_q;
  csc_guard_t  guard_q;
  logic        wr_io;
  logic        key_wr;
  logic        win_close;

  assign wr_io  = lnk.io_we;
  assign key_wr = wr_io && lnk.io_addr == `CSC_IO_GUARD &&
                  (lnk.io_wdata == `CSC_KEY_IO || lnk.io_wdata == `CSC_KEY_SPM);

  always_comb
  begin
    case (lnk.io_addr)
      `CSC_IO_GUARD: io_rd_mux = {6'h00, guard_q == CSC_G_SPM, guard_q == CSC_G_IO}; // RL23
      `CSC_IO_TEMP:  io_rd_mux = temp_q; // RL18
      `CSC_IO_SP_LO: io_rd_mux = sp_q[7:0];
      `CSC_IO_SP_HI: io_rd_mux = temp_q; // RL15
      default:       io_rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      io_rdata_q <= 8'h00;
    else if (lnk.io_re)
      io_rdata_q <= io_rd_mux;
  end
  assign lnk.io_rdata = io_rdata_q;

  // temp byte shared by both halves of the pointer and by direct access
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      temp_q <= 8'h00;
    else if (wr_io && (lnk.io_addr == `CSC_IO_SP_LO || lnk.io_addr == `CSC_IO_TEMP))
      temp_q <= lnk.io_wdata; // RL14 RL18
    else if (lnk.io_re && lnk.io_addr == `CSC_IO_SP_LO)
      temp_q <= sp_q[15:8] & SP_MASK[15:8]; // RL15
  end

  // hold-off after a low pointer write; the next i/o write ends it early
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      hold_q <= 3'h0;
    else if (wr_io && lnk.io_addr == `CSC_IO_SP_LO)
      hold_q <= `CSC_WIN_INSNS; // RL6
    else if (wr_io)
      hold_q <= 3'h0; // RL6
    else if (lnk.instr_retire && hold_q != 3'h0)
      hold_q <= hold_q - 3'h1; // RL6
  end

  ////////////////////////////////////////////////////////////////////////////
  // change guard

  // the key write itself is an i/o write but must not close its own window
  assign win_close = (wr_io && !key_wr) || lnk.data_we || lnk.nvm_access ||
                     lnk.sleep_exec; // RL21

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      guard_q <= CSC_G_IDLE;
      win_q   <= 3'h0;
    end
    else if (key_wr)
    begin
      guard_q <= (lnk.io_wdata == `CSC_KEY_IO) ? CSC_G_IO : CSC_G_SPM; // RL19 RL22
      win_q   <= `CSC_WIN_INSNS; // RL22
    end
    else if (win_close || (lnk.instr_retire && win_q == 3'h1))
    begin
      guard_q <= CSC_G_IDLE; // RL21 RL22
      win_q   <= 3'h0;
    end
    else if (lnk.instr_retire && win_q != 3'h0)
      win_q <= win_q - 3'h1; // RL22
  end

  assign lnk.guard_io_open  = guard_q == CSC_G_IO; // RL19
  assign lnk.guard_spm_open = guard_q == CSC_G_SPM; // RL19
  // the interrupt controller keeps flagging requests; only dispatch waits
  assign lnk.irq_block = guard_q != CSC_G_IDLE || hold_q != 3'h0; // RL24 RL6

  ////////////////////////////////////////////////////////////////////////////
  // stack engine

  csc_sq_t     sq_q;
  logic        sq_is_call_q;
  logic [7:0]  hold_byte_q;
  logic [7:0]  pop_q;
  logic [15:0] ret_pc_q;
  logic [15:0] sp_inc;
  logic [15:0] ret_word;

  assign sp_inc   = (sp_q + 16'h0001) & SP_MASK;
  assign ret_word = lnk.stk_pc_byte[16:1]; // RL4

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      sq_q         <= CSC_SQ_IDLE;
      sq_is_call_q <= 1'b0;
      hold_byte_q  <= 8'h00;
    end
    else
    begin
      case (sq_q)
        CSC_SQ_IDLE:
        begin
          if (lnk.stk_op == CSC_STK_CALL)
          begin
            sq_q         <= CSC_SQ_SECOND; // RL3
            sq_is_call_q <= 1'b1;
            hold_byte_q  <= ret_word[15:8];
          end
          else if (lnk.stk_op == CSC_STK_RET)
          begin
            sq_q         <= CSC_SQ_SECOND; // RL5
            sq_is_call_q <= 1'b0;
            hold_byte_q  <= lnk.stk_rdata; // RL5
          end
        end
        CSC_SQ_SECOND: sq_q <= CSC_SQ_IDLE;
        default:       sq_q <= CSC_SQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      pop_q    <= 8'h00;
      ret_pc_q <= 16'h0000;
    end
    else if (sq_q == CSC_SQ_IDLE && lnk.stk_op == CSC_STK_POP)
      pop_q <= lnk.stk_rdata; // RL1
    else if (sq_q == CSC_SQ_SECOND && !sq_is_call_q)
      ret_pc_q <= {hold_byte_q, lnk.stk_rdata}; // RL5
  end

  // stack engine owns the pointer over i/o writes when both fire together
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      sp_q <= SRAM_TOP & SP_MASK; // RL2
    else if (sq_q == CSC_SQ_SECOND)
      sp_q <= sq_is_call_q ? ((sp_q - 16'h0001) & SP_MASK) : sp_inc; // RL3 RL5
    else if (lnk.stk_op == CSC_STK_PUSH || lnk.stk_op == CSC_STK_CALL)
      sp_q <= (sp_q - 16'h0001) & SP_MASK; // RL1 RL3
    else if (lnk.stk_op == CSC_STK_POP || lnk.stk_op == CSC_STK_RET)
      sp_q <= sp_inc; // RL1 RL5
    else if (wr_io && lnk.io_addr == `CSC_IO_SP_HI)
      sp_q <= {lnk.io_wdata, temp_q} & SP_MASK; // RL14
  end

  // memory port: pushes write at the pointer, pops read one above it
  always_comb
  begin
    lnk.stk_we    = 1'b0;
    lnk.stk_wdata = 8'h00;
    lnk.stk_addr  = sp_q;
    if (sq_q == CSC_SQ_SECOND)
    begin
      lnk.stk_we    = sq_is_call_q;
      lnk.stk_wdata = hold_byte_q; // RL3
      lnk.stk_addr  = sq_is_call_q ? sp_q : sp_inc;
    end
    else if (lnk.stk_op == CSC_STK_PUSH)
    begin
      lnk.stk_we    = 1'b1;
      lnk.stk_wdata = lnk.stk_push_data; // RL1
    end
    else if (lnk.stk_op == CSC_STK_CALL)
    begin
      lnk.stk_we    = 1'b1;
      lnk.stk_wdata = ret_word[7:0]; // RL3
    end
    else if (lnk.stk_op == CSC_STK_POP || lnk.stk_op == CSC_STK_RET)
      lnk.stk_addr = sp_inc;
  end

  assign lnk.stk_busy     = sq_q != CSC_SQ_IDLE;
  assign lnk.stk_pop_data = pop_q;
  assign lnk.stk_ret_pc   = ret_pc_q;
endmodule
`default_nettype wire

/* design/csc_seq.sv */
// csc_seq: sequencer end; runs one command per avalon command-register write, owns stack ram
// assumes: avalon-mm master on clk_sys, core on csc_link_if.seq
`include "csc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module csc_seq
  import csc_pkg::*;
#(
  parameter int STK_DEPTH = 256
)(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  // avalon-mm slave
  input  wire logic [1:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // link to the core
  csc_link_if.seq          lnk
);
  initial
  begin
    if (STK_DEPTH < 4 || STK_DEPTH > 65536 || (STK_DEPTH & (STK_DEPTH - 1)) != 0)
      $error("csc_seq: STK_DEPTH must be a power of two, 4..65536");
  end

  localparam int AW = $clog2(STK_DEPTH);

  csc_hst_t    st_q;
  logic [31:0] cmd_q;
  logic [31:0] data_q;
  logic [31:0] res_q;
  logic [31:0] rdata_q;
  logic        rd_ack_q;
  logic [2:0]  flags_q;
  logic [7:0]  stk_mem [STK_DEPTH];
  csc_cmd_t    op;
  logic        iss;
  logic [5:0]  ioa;
  logic        cmd_wr;

  assign op     = csc_cmd_t'(cmd_q[`CSC_CMD_OP_LSB +: 4]);
  assign iss    = st_q == CSC_H_ISSUE;
  assign ioa    = cmd_q[`CSC_CMD_ADR_LSB +: 6];
  assign cmd_wr = avs_write && avs_address == `CSC_HR_CMD && st_q == CSC_H_IDLE;

  ////////////////////////////////////////////////////////////////////////////
  // avalon slave: reads answer one cycle late, command writes stall while busy

  assign avs_waitrequest = (avs_read && !rd_ack_q) ||
                           (avs_write && avs_address == `CSC_HR_CMD && st_q != CSC_H_IDLE);
  assign avs_readdata    = rdata_q;

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      rd_ack_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
    end
    else
    begin
      rd_ack_q <= avs_read && !rd_ack_q;
      case (avs_address)
        `CSC_HR_CMD:    rdata_q <= cmd_q;
        `CSC_HR_DATA:   rdata_q <= data_q;
        `CSC_HR_RESULT: rdata_q <= res_q;
        default:        rdata_q <= {28'h000_0000, st_q != CSC_H_IDLE, flags_q};
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      cmd_q  <= 32'h0000_0000;
      data_q <= 32'h0000_0000;
    end
    else if (cmd_wr)
      cmd_q <= avs_writedata;
    else if (avs_write && avs_address == `CSC_HR_DATA)
      data_q <= avs_writedata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // command sequencer

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      st_q  <= CSC_H_IDLE;
      res_q <= 32'h0000_0000;
    end
    else
    begin
      case (st_q)
        CSC_H_IDLE:  if (cmd_wr) st_q <= CSC_H_ISSUE;
        CSC_H_ISSUE: st_q <= CSC_H_WAIT;
        CSC_H_WAIT:
        begin
          if (!lnk.stk_busy)
          begin
            st_q <= CSC_H_IDLE;
            case (op)
              CSC_C_IO_RD: res_q <= {24'h00_0000, lnk.io_rdata};
              CSC_C_RF_RD: res_q <= {lnk.rf_rd_w, lnk.rf_rd_b, lnk.rf_rd_a};
              CSC_C_POP:   res_q <= {24'h00_0000, lnk.stk_pop_data};
              CSC_C_RET:   res_q <= {16'h0000, lnk.stk_ret_pc};
              CSC_C_PTR:   res_q <= {16'h0000, lnk.ptr_ea};
              default:     res_q <= res_q;
            endcase
          end
        end
        default: st_q <= CSC_H_IDLE;
      endcase
    end
  end

  // every command stands for one executed instruction
  assign lnk.instr_retire  = iss;
  assign lnk.data_we       = iss && op == CSC_C_DATA_WR;
  assign lnk.nvm_access    = iss && op == CSC_C_NVM;
  assign lnk.sleep_exec    = iss && op == CSC_C_SLEEP;
  assign lnk.io_addr       = ioa;
  assign lnk.io_wdata      = data_q[7:0];
  assign lnk.io_we         = iss && op == CSC_C_IO_WR;
  assign lnk.io_re         = iss && op == CSC_C_IO_RD;
  assign lnk.rf_ra_a       = cmd_q[`CSC_CMD_ADR_LSB +: 5];
  assign lnk.rf_ra_b       = data_q[20:16];
  assign lnk.rf_wa         = cmd_q[`CSC_CMD_ADR_LSB +: 5];
  assign lnk.rf_wd         = data_q[15:0];
  assign lnk.rf_we8        = iss && op == CSC_C_RF_WR8;
  assign lnk.rf_we16       = iss && op == CSC_C_RF_WR16;
  assign lnk.ptr_go        = iss && op == CSC_C_PTR;
  assign lnk.ptr_sel       = csc_ptr_t'(cmd_q[`CSC_CMD_SEL_LSB +: 2]);
  assign lnk.ptr_mode      = csc_am_t'(cmd_q[`CSC_CMD_AM_LSB +: 2]);
  assign lnk.ptr_zonly     = cmd_q[`CSC_CMD_ZONLY_BIT]; // RL11
  assign lnk.ptr_disp      = cmd_q[`CSC_CMD_DISP_LSB +: 6];
  assign lnk.stk_push_data = data_q[7:0];
  assign lnk.stk_pc_byte   = data_q[16:0];
  assign lnk.stk_rdata     = stk_mem[lnk.stk_addr[AW-1:0]];

  always_comb
  begin
    lnk.stk_op = CSC_STK_NONE;
    if (iss)
    begin
      case (op)
        CSC_C_PUSH: lnk.stk_op = CSC_STK_PUSH;
        CSC_C_POP:  lnk.stk_op = CSC_STK_POP;
        CSC_C_CALL: lnk.stk_op = CSC_STK_CALL;
        CSC_C_RET:  lnk.stk_op = CSC_STK_RET;
        default:    lnk.stk_op = CSC_STK_NONE;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (lnk.stk_we)
      stk_mem[lnk.stk_addr[AW-1:0]] <= lnk.stk_wdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // software-discipline monitors, sticky, write one to clear, set wins

  logic       lo_wr_q;
  logic       lo_rd_q;
  logic [7:0] lo_val_q;
  logic       io_prev_q;
  logic       pw_seen_q;
  logic [2:0] f_set;

  always_comb
  begin
    f_set    = 3'h0;
    f_set[0] = (lnk.io_we && ioa == `CSC_IO_SP_HI && !lo_wr_q) ||
               (lnk.io_re && ioa == `CSC_IO_SP_HI && !lo_rd_q); // RL16 RL17
    f_set[1] = lnk.io_we && ioa == `CSC_IO_SP_HI &&
               {data_q[7:0], lo_val_q} <= `CSC_STACK_FLOOR; // RL7
    f_set[2] = io_prev_q && !lnk.guard_io_open && !pw_seen_q; // RL20
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      flags_q   <= 3'h0;
      lo_wr_q   <= 1'b0;
      lo_rd_q   <= 1'b0;
      lo_val_q  <= 8'h00;
      io_prev_q <= 1'b0;
      pw_seen_q <= 1'b0;
    end
    else
    begin
      if (avs_write && avs_address == `CSC_HR_STATUS)
        flags_q <= (flags_q & ~avs_writedata[2:0]) | f_set;
      else
        flags_q <= flags_q | f_set;
      if (lnk.io_we && ioa == `CSC_IO_SP_LO)
      begin
        lo_wr_q  <= 1'b1; // RL16
        lo_val_q <= data_q[7:0];
      end
      else if (lnk.io_we && ioa == `CSC_IO_SP_HI)
        lo_wr_q <= 1'b0;
      if (lnk.io_re && ioa == `CSC_IO_SP_LO)
        lo_rd_q <= 1'b1; // RL17
      else if (lnk.io_re && ioa == `CSC_IO_SP_HI)
        lo_rd_q <= 1'b0;
      io_prev_q <= lnk.guard_io_open;
      if (!lnk.guard_io_open)
        pw_seen_q <= 1'b0;
      else if (lnk.io_we && ioa != `CSC_IO_GUARD)
        pw_seen_q <= 1'b1; // RL20
    end
  end
endmodule
`default_nettype wire

/* tb/csc_checker.sv */
// csc_checker: assertions on the sequencer-to-core link
// assumes: instanced beside csc_link_if in the bench top
`include "csc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module csc_checker
  import csc_pkg::*;
(
  // clock and reset
  input wire logic        clk_sys, nrst,
  // instruction events and i/o writes
  input wire logic        data_we, nvm_access, sleep_exec, io_we,
  input wire logic [5:0]  io_addr,
  input wire logic [7:0]  io_wdata,
  // stack
  input wire csc_stk_op_t stk_op,
  input wire logic [7:0]  stk_push_data, stk_wdata,
  input wire logic [16:0] stk_pc_byte,
  input wire logic        stk_busy, stk_we,
  input wire logic [15:0] stk_addr,
  // status
  input wire logic        irq_block, guard_io_open, guard_spm_open
);
  logic [16:0] pc_q;
  logic [15:0] adr_q;
  wire logic   open_w = guard_io_open | guard_spm_open;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // second byte of call and return is judged against the cycle before
  always_ff @(posedge clk_sys) pc_q <= stk_pc_byte;
  always_ff @(posedge clk_sys) adr_q <= stk_addr;
  ////////////////////////////////////////
  sequence s_call_lo; stk_we && !stk_busy && stk_wdata == stk_pc_byte[8:1]; endsequence
  sequence s_call_hi;
    stk_busy && stk_we && stk_wdata == pc_q[16:9] && stk_addr == adr_q - 16'h1;
  endsequence
  property p_push; stk_op == CSC_STK_PUSH |-> stk_we && stk_wdata == stk_push_data; endproperty
  property p_call; stk_op == CSC_STK_CALL |-> s_call_lo ##1 s_call_hi; endproperty
  property p_ret;
    stk_op == CSC_STK_RET |-> !stk_we ##1 stk_busy && !stk_we && stk_addr == adr_q + 16'h1;
  endproperty
  property p_key_io;
    io_we && io_addr == `CSC_IO_GUARD && io_wdata == `CSC_KEY_IO |=> guard_io_open;
  endproperty
  property p_one_mode; !(guard_io_open && guard_spm_open); endproperty
  property p_close; open_w && (data_we || nvm_access || sleep_exec) |=> !open_w; endproperty
  property p_hold; open_w |-> irq_block; endproperty
  property p_sp_lo; io_we && io_addr == `CSC_IO_SP_LO |=> irq_block; endproperty
  a_push: assert property (p_push) else $error("push write");
  a_call: assert property (p_call) else $error("call push");
  a_ret: assert property (p_ret) else $error("return pop");
  a_key_io: assert property (p_key_io) else $error("io key");
  a_one_mode: assert property (p_one_mode) else $error("two modes");
  a_close: assert property (p_close) else $error("window close");
  a_hold: assert property (p_hold) else $error("irq hold");
  a_sp_lo: assert property (p_sp_lo) else $error("sp low hold");
endmodule
`default_nettype wire

/* tb/test_cpu_stack_regfile_ccp.sv */
// test_cpu_stack_regfile_ccp: sequencer and core joined, driven over avalon
// assumes: design files and csc_checker compiled first
`timescale 1ns/1ps
`default_nettype none
module test_cpu_stack_regfile_ccp;
  localparam logic [15:0] TOP = 16'h3fff;
  logic        clk_sys = 1'b0;
  logic        nrst = 1'b0;
  logic [1:0]  avs_address = 2'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [31:0] r;
  int          err_total = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  csc_link_if lnk ();
  csc_core #(.SRAM_TOP(TOP)) i_csc_core (.clk_sys(clk_sys), .nrst(nrst), .lnk(lnk));
  csc_seq i_csc_seq (.clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .lnk(lnk));
  csc_checker i_csc_checker (.clk_sys(clk_sys), .nrst(nrst), .data_we(lnk.data_we),
    .nvm_access(lnk.nvm_access), .sleep_exec(lnk.sleep_exec), .io_we(lnk.io_we),
    .io_addr(lnk.io_addr), .io_wdata(lnk.io_wdata), .stk_op(lnk.stk_op),
    .stk_push_data(lnk.stk_push_data), .stk_wdata(lnk.stk_wdata),
    .stk_pc_byte(lnk.stk_pc_byte), .stk_busy(lnk.stk_busy), .stk_we(lnk.stk_we),
    .stk_addr(lnk.stk_addr), .irq_block(lnk.irq_block),
    .guard_io_open(lnk.guard_io_open), .guard_spm_open(lnk.guard_spm_open));
  always #25 clk_sys = ~clk_sys;
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  // held until waitrequest is low at an edge; read data taken there
  task automatic av(input logic [1:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    @(posedge clk_sys iff avs_waitrequest === 1'b0);
    r = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic cmd(input logic [3:0] op, input logic [5:0] a, input logic [31:0] d = 0,
                     input logic [15:0] hi = 16'h0);
    av(2'h1, 1'b1, d);
    av(2'h0, 1'b1, {hi, 2'h0, a, 4'h0, op});
    do av(2'h3, 1'b0, 32'h0); while (r[3] !== 1'b0);
    av(2'h2, 1'b0, 32'h0);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    cmd(4'h2, a);
    chk(r[7:0], e);
  endtask
  task automatic t_stack;
    rd(6'h0d, TOP[7:0]);
    rd(6'h0e, TOP[15:8]);
    cmd(4'h6, 6'h0, 32'ha5);
    rd(6'h0d, TOP[7:0] - 8'h1);
    cmd(4'h6, 6'h0, 32'h3c);
    cmd(4'h7, 6'h0);
    chk(r[7:0], 8'h3c);
    cmd(4'h7, 6'h0);
    chk(r[7:0], 8'ha5);
    cmd(4'h8, 6'h0, 32'h12346);
    rd(6'h0d, TOP[7:0] - 8'h2);
    cmd(4'h9, 6'h0);
    chk(r[15:0], 16'h91a3);
    rd(6'h0d, TOP[7:0]);
    $display("stack done");
  endtask
  task automatic t_regs;
    cmd(4'h3, 6'h05, 32'h5a);
    cmd(4'h3, 6'h06, 32'hc3);
    cmd(4'h1, 6'h05, 32'hff);
    cmd(4'h5, 6'h05, 32'h0006_0000);
    chk(r[15:0], 16'hc35a);
    cmd(4'h4, 6'h1e, 32'h1234);
    cmd(4'h5, 6'h1e, 32'h001f_0000);
    chk(r[15:0], 16'h1234);
    cmd(4'ha, 6'h0, 32'h0, 16'h0006);
    chk(r[15:0], 16'h1234);
    cmd(4'ha, 6'h0, 32'h0, 16'h0302);
    chk(r[15:0], 16'h1238);
    // x selected, but the z-only flag must win
    cmd(4'ha, 6'h0, 32'h0, 16'h0018);
    chk(r[15:0], 16'h1234);
    $display("regs done");
  endtask
  task automatic t_guard;
    logic [3:0] cl [4] = '{4'h1, 4'hb, 4'hc, 4'hd};
    foreach (cl[i])
    begin
      cmd(4'h1, 6'h04, i[0] ? 32'h9d : 32'hd8);
      rd(6'h04, i[0] ? 8'h02 : 8'h01);
      cmd(cl[i], 6'h0);
      rd(6'h04, 8'h00);
    end
    cmd(4'h1, 6'h04, 32'hd8);
    repeat (2) cmd(4'h0, 6'h0);
    rd(6'h04, 8'h01);
    cmd(4'h0, 6'h0);
    rd(6'h04, 8'h00);
    av(2'h3, 1'b0, 32'h0);
    chk(r[2:0], 3'h4);
    $display("guard done");
  endtask
  task automatic t_temp;
    cmd(4'h1, 6'h08, 32'h77);
    rd(6'h08, 8'h77);
    cmd(4'h1, 6'h0d, 32'h10);
    rd(6'h08, 8'h10);
    cmd(4'h1, 6'h0e, 32'h21);
    rd(6'h0d, 8'h10);
    rd(6'h0e, 8'h21);
    $display("temp done");
  endtask
  task automatic complete_run;
    $display("checked %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    t_stack();
    t_regs();
    t_guard();
    t_temp();
    complete_run();
  end
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      err_total++;
      complete_run();
    end
  end
endmodule
`default_nettype wire
